// *** design/i2mc_ctrl.v ***
// I2C control register upper bits: enable, start, stop, baud timer
// Operation
// (R01) The controller runs only while the enable bit is set.
// (R02) Start request makes a start condition, then self-clears; disable clears it.
// (R03) Writing 0 to a set start request leaves it set.
// (R04) A start is issued only when the data or shift register holds a byte.
// (R05) Start requested mid-byte gives a repeated start after byte and acknowledge.
// (R06) With stop and start both pending, the stop goes first, then the start.
// (R07) Start during an addressed slave transaction clears it and flags arbitration lost.
// (R08) Stop request makes a stop after the current byte sent or byte received.
// (R09) Stop request self-clears once the stop is sent; disable clears it too.
// (R10) Writing 0 to a set stop request does not clear it.
// (R11) Stop during a slave transaction is cleared with no stop condition.
// (R12) The baud timer interrupt select is ignored while enabled.
// (R13) Disabled with timer select set, the baud generator runs as a timer.
// (R14) Request bits are set by a 1 only while enabled, never cleared by a 0.
// (R15) The timer interrupt is a one-cycle pulse at each reload.
//
// Local design decision: strobed register access.
`timescale 1ns/1ps
`include "i2mc_defs.vh"
module i2mc_ctrl (
	input  wire                    mclk_i,
	input  wire                    arst_n_i,
	input  wire [`I2MC_ADDR_W-1:0] addr_i,
	input  wire [7:0]              wdata_i,
	input  wire                    wr_i,
	input  wire                    rd_i,
	output reg  [7:0]              rdata_o,
	input  wire                    data_loaded_i,
	input  wire                    byte_busy_i,
	input  wire                    byte_done_i,
	input  wire                    slave_active_i,
	input  wire                    cond_done_i,
	output reg                     ctrl_enable_o,
	output reg                     send_start_o,
	output reg                     send_stop_o,
	output reg                     arb_lost_o,
	output reg                     timer_pulse_o,
	output reg                     irq_o
);
	localparam ST_IDLE  = 4'b0001;
	localparam ST_START = 4'b0010;
	localparam ST_STOP  = 4'b0100;
	localparam ST_WAIT  = 4'b1000;

	reg                    rst_s1_reg;
	reg                    rst_s2_reg;
	reg                    en_reg;
	reg                    en_next;
	reg                    baud_timer_irq_select_reg;
	reg                    baud_timer_irq_select_next;
	reg  [3:0]             low_reg;
	reg  [3:0]             low_next;
	reg  [7:0]             cnt_next;
	reg  [7:0]             rdata_next;
	wire                   start_reg;
	wire                   stop_reg;
	wire                   start_clr;
	wire                   stop_clr;
	wire                   stat_wr;
	reg  [3:0]             state_reg;
	reg  [3:0]             state_next;
	reg  [7:0]             baud_reg;
	reg  [7:0]             cnt_reg;
	wire [`I2MC_EV_W-1:0]  stat_reg;
	reg  [`I2MC_EV_W-1:0]  mask_reg;
	reg                    after_byte_reg;
	wire                   rst_n;
	wire                   ctl_wr;
	wire                   timer_run;
	wire                   timer_hit;
	wire                   go_start;
	wire                   go_stop;
	wire                   start_kill;
	wire                   stop_kill;
	wire                   start_done;
	wire                   stop_done;
	wire [`I2MC_EV_W-1:0]  ev;

	assign rst_n = rst_s2_reg;

	always @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rst_s1_reg <= 1'b0;
			rst_s2_reg <= 1'b0;
		end else begin
			rst_s1_reg <= 1'b1;
			rst_s2_reg <= rst_s1_reg;
		end
	end

	assign ctl_wr = wr_i && (addr_i == `I2MC_CTL_ADDR);
	// Byte boundary: no byte shifting, or byte and acknowledge just done
	assign go_stop = en_reg && stop_reg && !slave_active_i &&
		(after_byte_reg || byte_done_i); // (R08)
	assign go_start = en_reg && start_reg && !stop_reg && !slave_active_i &&
		data_loaded_i && (!byte_busy_i || byte_done_i); // (R04) (R05) (R06)
	assign start_kill = en_reg && start_reg && slave_active_i; // (R07)
	assign stop_kill = en_reg && stop_reg && slave_active_i; // (R11)
	assign start_done = (state_reg == ST_START) && cond_done_i;
	assign stop_done = (state_reg == ST_STOP) && cond_done_i;
	assign timer_run = !en_reg && baud_timer_irq_select_reg; // (R12) (R13)
	assign timer_hit = timer_run && (cnt_reg == 8'h01);

	always @* begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE: begin
				if (go_stop)
					state_next = ST_STOP;
				else if (go_start)
					state_next = ST_START;
			end
			ST_START: begin
				if (cond_done_i)
					state_next = ST_WAIT;
			end
			ST_STOP: begin
				if (cond_done_i)
					state_next = ST_WAIT;
			end
			ST_WAIT: state_next = ST_IDLE;
			default: state_next = ST_IDLE;
		endcase
		if (!en_reg)
			state_next = ST_IDLE; // (R01)
	end

	always @(posedge mclk_i or negedge rst_n) begin
		if (!rst_n) begin
			en_reg         <= 1'b0;
			baud_timer_irq_select_reg       <= 1'b0;
			low_reg        <= 4'h0;
			state_reg      <= ST_IDLE;
			after_byte_reg <= 1'b1;
		end else begin
			state_reg <= state_next;
			if (byte_busy_i && !byte_done_i)
				after_byte_reg <= 1'b0;
			else
				after_byte_reg <= 1'b1;
			en_reg   <= en_next;
			baud_timer_irq_select_reg <= baud_timer_irq_select_next;
			low_reg  <= low_next;
		end
	end

	// Control field write
	always @* begin
		en_next   = en_reg;
		baud_timer_irq_select_next = baud_timer_irq_select_reg;
		low_next  = low_reg;
		if (ctl_wr) begin
			en_next   = wdata_i[`I2MC_BIT_EN]; // (R01)
			baud_timer_irq_select_next = wdata_i[`I2MC_BIT_BAUD_TIMER_IRQ_SELECT]; // (R12)
			low_next  = wdata_i[3:0];
		end
	end

	assign start_clr = start_done || start_kill; // (R02) (R07)
	assign stop_clr  = stop_done || stop_kill; // (R09) (R11)

	// Start request: set-only, cleared by hardware or disable
	i2mc_req_bit u_start_req (
		.mclk_i   (mclk_i),
		.rst_n_i  (rst_n),
		.en_i     (en_reg),
		.wr_i     (ctl_wr),
		.wr_en_i  (wdata_i[`I2MC_BIT_EN]),
		.wr_bit_i (wdata_i[`I2MC_BIT_START]), // (R03) (R14)
		.hw_clr_i (start_clr),
		.req_o    (start_reg)
	);

	// Stop request: set-only, cleared by hardware or disable
	i2mc_req_bit u_stop_req (
		.mclk_i   (mclk_i),
		.rst_n_i  (rst_n),
		.en_i     (en_reg),
		.wr_i     (ctl_wr),
		.wr_en_i  (wdata_i[`I2MC_BIT_EN]),
		.wr_bit_i (wdata_i[`I2MC_BIT_STOP]), // (R10) (R14)
		.hw_clr_i (stop_clr),
		.req_o    (stop_reg)
	);

	always @(posedge mclk_i or negedge rst_n) begin
		if (!rst_n) begin
			cnt_reg       <= `I2MC_BAUD_RESET;
			baud_reg      <= `I2MC_BAUD_RESET;
			timer_pulse_o <= 1'b0;
		end else begin
			if (wr_i && addr_i == `I2MC_BAUD_ADDR)
				baud_reg <= wdata_i;
			timer_pulse_o <= timer_hit; // (R15)
			cnt_reg       <= cnt_next;
		end
	end

	// Baud timer reload and count down
	always @* begin
		cnt_next = cnt_reg - 8'h01;
		if (!timer_run)
			cnt_next = baud_reg;
		else if (timer_hit || cnt_reg == 8'h00)
			cnt_next = baud_reg; // (R13)
	end

	assign ev = {start_done, stop_done, start_kill, timer_hit};
	assign stat_wr = wr_i && (addr_i == `I2MC_INT_STAT_ADDR);

	always @(posedge mclk_i or negedge rst_n) begin
		if (!rst_n)
			mask_reg <= {`I2MC_EV_W{1'b0}};
		else if (wr_i && addr_i == `I2MC_INT_MASK_ADDR)
			mask_reg <= wdata_i[`I2MC_EV_W-1:0];
	end

	// Sticky status bits, write one to clear, set wins
	genvar gi;
	generate
		for (gi = 0; gi < `I2MC_EV_W; gi = gi + 1) begin : g_stat
			i2mc_sticky_bit u_bit (
				.mclk_i  (mclk_i),
				.rst_n_i (rst_n),
				.clr_i   (stat_wr && wdata_i[gi]),
				.set_i   (ev[gi]),
				.stat_o  (stat_reg[gi])
			);
		end
	endgenerate

	// Register read select
	always @* begin
		rdata_next = 8'h00;
		if (rd_i) begin
			case (addr_i)
				`I2MC_CTL_ADDR:
					rdata_next = {en_reg, start_reg, stop_reg,
						baud_timer_irq_select_reg, low_reg};
				`I2MC_INT_STAT_ADDR:
					rdata_next = {4'h0, stat_reg};
				`I2MC_INT_MASK_ADDR:
					rdata_next = {4'h0, mask_reg};
				`I2MC_BAUD_ADDR:
					rdata_next = baud_reg;
				default:
					rdata_next = 8'h00;
			endcase
		end
	end

	always @(posedge mclk_i or negedge rst_n) begin
		if (!rst_n) begin
			rdata_o       <= 8'h00;
			ctrl_enable_o <= 1'b0;
			send_start_o  <= 1'b0;
			send_stop_o   <= 1'b0;
			arb_lost_o    <= 1'b0;
			irq_o         <= 1'b0;
		end else begin
			ctrl_enable_o <= en_reg; // (R01)
			send_start_o  <= (state_next == ST_START);
			send_stop_o   <= (state_next == ST_STOP);
			arb_lost_o    <= start_kill; // (R07)
			irq_o <= |((stat_reg | ev) & mask_reg);
			rdata_o       <= rdata_next;
		end
	end
endmodule // i2mc_ctrl

// Set-only request bit; a written 0 never clears it
module i2mc_req_bit (
	input  wire mclk_i,
	input  wire rst_n_i,
	input  wire en_i,
	input  wire wr_i,
	input  wire wr_en_i,
	input  wire wr_bit_i,
	input  wire hw_clr_i,
	output reg  req_o
);
	always @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			req_o <= 1'b0;
		else if (!en_i || (wr_i && !wr_en_i))
			req_o <= 1'b0; // (R02) (R09)
		else if (wr_i && wr_bit_i)
			req_o <= 1'b1; // (R14)
		else if (hw_clr_i)
			req_o <= 1'b0;
	end
endmodule // i2mc_req_bit

// Sticky event bit; an event in the clear cycle keeps it set
module i2mc_sticky_bit (
	input  wire mclk_i,
	input  wire rst_n_i,
	input  wire clr_i,
	input  wire set_i,
	output reg  stat_o
);
	always @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			stat_o <= 1'b0;
		else if (set_i)
			stat_o <= 1'b1;
		else if (clr_i)
			stat_o <= 1'b0;
	end
endmodule // i2mc_sticky_bit

// *** design/i2mc_defs.vh ***
// Constants for the I2C master control bits block
`ifndef I2MC_DEFS_VH
`define I2MC_DEFS_VH
`define I2MC_ADDR_W        12
`define I2MC_CTL_ADDR      12'hF52
`define I2MC_INT_STAT_ADDR 12'hF60
`define I2MC_INT_MASK_ADDR 12'hF61
`define I2MC_BAUD_ADDR     12'hF62
`define I2MC_CTL_RESET     8'h00
`define I2MC_BAUD_RESET    8'h10
`define I2MC_BIT_EN        7
`define I2MC_BIT_START     6
`define I2MC_BIT_STOP      5
`define I2MC_BIT_BAUD_TIMER_IRQ_SELECT      4
`define I2MC_EV_TIMER      0
`define I2MC_EV_ARBLOST    1
`define I2MC_EV_STOPDONE   2
`define I2MC_EV_STARTDONE  3
`define I2MC_EV_W          4
`endif

// *** dv/i2mc_ctrl_sva.sv ***
// Port assertions for the control block
`timescale 1ns/1ps
module i2mc_ctrl_sva (
	input logic mclk_i, arst_n_i, data_loaded_i, byte_busy_i, byte_done_i,
	input logic slave_active_i, cond_done_i, ctrl_enable_o,
	input logic send_start_o, send_stop_o, arb_lost_o, timer_pulse_o
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!arst_n_i);
	property p_en; send_start_o || send_stop_o |-> ctrl_enable_o; endproperty
	a_en: assert property (p_en) else $error("bad enable");
	property p_dat; $rose(send_start_o) |-> $past(data_loaded_i); endproperty
	a_dat: assert property (p_dat) else $error("no data");
	property p_bsy;
		$rose(send_start_o) |-> !$past(byte_busy_i) || $past(byte_done_i);
	endproperty
	a_bsy: assert property (p_bsy) else $error("mid byte");
	property p_ord; !(send_start_o && send_stop_o); endproperty
	a_ord: assert property (p_ord) else $error("both");
	property p_scl; send_start_o && cond_done_i |=> !send_start_o; endproperty
	a_scl: assert property (p_scl) else $error("start held");
	property p_pcl; send_stop_o && cond_done_i |=> !send_stop_o; endproperty
	a_pcl: assert property (p_pcl) else $error("stop held");
	property p_slv; $rose(send_stop_o) |-> !$past(slave_active_i); endproperty
	a_slv: assert property (p_slv) else $error("stop in slave");
	property p_arb; arb_lost_o |-> $past(slave_active_i); endproperty
	a_arb: assert property (p_arb) else $error("bad arb");
	property p_tmr;
		timer_pulse_o |-> !$past(ctrl_enable_o) ##1 !timer_pulse_o;
	endproperty
	a_tmr: assert property (p_tmr) else $error("bad tick");
	cover property (send_stop_o && cond_done_i);
	cover property (arb_lost_o);
	cover property (timer_pulse_o);
endmodule // i2mc_ctrl_sva
bind i2mc_ctrl i2mc_ctrl_sva chk (.mclk_i(mclk_i), .arst_n_i(arst_n_i),
	.data_loaded_i(data_loaded_i), .byte_busy_i(byte_busy_i),
	.byte_done_i(byte_done_i),
	.slave_active_i(slave_active_i), .cond_done_i(cond_done_i),
	.ctrl_enable_o(ctrl_enable_o), .send_start_o(send_start_o),
	.send_stop_o(send_stop_o), .arb_lost_o(arb_lost_o),
	.timer_pulse_o(timer_pulse_o));

// *** dv/i2mc_line_model.sv ***
// Bus line engine: ends a start or stop condition after dly+1 cycles
`timescale 1ns/1ps
module i2mc_line_model (
	input  logic       clk,
	input  logic       go,
	input  logic [3:0] dly,
	output logic       done
);
	logic [3:0] cnt = 4'h0;
	initial done = 1'h0;
	always @(posedge clk) begin
		done <= 1'h0;
		if (!go)
			cnt <= 4'h0;
		else if (cnt == dly) begin
			done <= 1'h1;
			cnt <= 4'h0;
		end else
			cnt <= cnt + 4'h1;
	end
endmodule // i2mc_line_model

// *** dv/i2mc_ctrl_tb.sv ***
// Self-checking bench for the control block
`timescale 1ns/1ps
module i2mc_ctrl_tb;
	logic        mclk, arst_n, wr, rd, dl, busy, bdone, slv, cdone;
	logic        en, st, sp, arb, tp, irq;
	logic [3:0]  dly;
	logic [11:0] addr;
	logic [7:0]  wdata, rdata, v;
	int          fails, n_checks, n;
	i2mc_ctrl uut (.mclk_i(mclk), .arst_n_i(arst_n), .addr_i(addr),
		.wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
		.data_loaded_i(dl), .byte_busy_i(busy), .byte_done_i(bdone),
		.slave_active_i(slv), .cond_done_i(cdone), .ctrl_enable_o(en),
		.send_start_o(st), .send_stop_o(sp), .arb_lost_o(arb),
		.timer_pulse_o(tp), .irq_o(irq));
	i2mc_line_model line (.clk(mclk), .go(st | sp), .dly(dly), .done(cdone));
	task chk(input logic [7:0] s, input logic [7:0] e);
		n_checks++;
		if (s !== e) begin
			fails++;
			$display("mismatch %0t %h %h", $time, s, e);
		end
	endtask
	task cyc(input int k);
		repeat (k) @(posedge mclk);
		#1;
	endtask
	task wrr(input logic [11:0] a, input logic [7:0] d);
		@(posedge mclk) begin
			addr <= a;
			wdata <= d;
			wr <= 1'h1;
		end
		@(posedge mclk) wr <= 1'h0;
	endtask
	task rdr(input logic [11:0] a);
		@(posedge mclk) begin
			addr <= a;
			rd <= 1'h1;
		end
		@(posedge mclk) rd <= 1'h0;
		#1 v = rdata;
	endtask
	task s_start;
		wrr(12'hF52, 8'h80);
		wrr(12'hF52, 8'hC0);
		cyc(4);
		chk(st, 1'h0);
		wrr(12'hF52, 8'h80);
		rdr(12'hF52);
		chk(v, 8'hC0);
		@(posedge mclk) dl <= 1'h1;
		for (n = 0; n < 30 && st !== 1'h1; n++) cyc(1);
		chk(st, 1'h1);
		cyc(6);
		rdr(12'hF52);
		chk(v, 8'h80);
		dly = 4'h6;
		wrr(12'hF52, 8'hE0);
		cyc(3);
		chk({sp, st}, 8'h02);
		cyc(30);
		rdr(12'hF52);
		chk(v, 8'h80);
	endtask
	task s_slave;
		wrr(12'hF60, 8'hFF);
		@(posedge mclk) slv <= 1'h1;
		wrr(12'hF52, 8'hC0);
		cyc(3);
		rdr(12'hF60);
		chk(v, 8'h02);
		wrr(12'hF52, 8'hA0);
		cyc(3);
		rdr(12'hF52);
		chk(v, 8'h80);
		chk(sp, 1'h0);
		@(posedge mclk) dl <= 1'h0;
		wrr(12'hF52, 8'hC0);
		wrr(12'hF52, 8'h00);
		wrr(12'hF52, 8'h60);
		rdr(12'hF52);
		chk(v, 8'h00);
		chk(en, 1'h0);
		rdr(12'hF70);
		chk(v, 8'h00);
	endtask
	task s_timer;
		wrr(12'hF61, 8'h01);
		wrr(12'hF52, 8'h10);
		for (n = 0; n < 40 && tp !== 1'h1; n++) cyc(1);
		cyc(1);
		for (n = 1; n < 40 && tp !== 1'h1; n++) cyc(1);
		chk(n[7:0], 8'h10);
		cyc(1);
		chk(irq, 1'h1);
		wrr(12'hF61, 8'h00);
		cyc(2);
		chk(irq, 1'h0);
		wrr(12'hF52, 8'h90);
		wrr(12'hF60, 8'hFF);
		cyc(40);
		rdr(12'hF60);
		chk(v, 8'h00);
	endtask
	task end_sim;
		if (fails == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		mclk = 1'h0;
		forever #5 mclk = ~mclk;
	end
	initial begin
		#20000;
		fails++;
		end_sim;
	end
	initial begin
		{arst_n, wr, rd, dl, busy, bdone, slv, addr, wdata} = 0;
		{fails, n_checks, dly} = 0;
		repeat (3) @(posedge mclk);
		arst_n <= 1'h1;
		cyc(4);
		rdr(12'hF62);
		chk(v, 8'h10);
		s_start;
		s_slave;
		s_timer;
		end_sim;
	end
endmodule // i2mc_ctrl_tb
